/* src/adc_scan_pkg.sv */
`default_nettype none
package adc_scan_pkg;

  // command byte layout
  localparam int CMD_W          = 8;
  localparam int CMD_CONV_BIT   = 7;
  localparam int CMD_SETUP_BIT  = 6;
  localparam int CONV_CH_HI     = 6;
  localparam int CONV_CH_LO     = 3;
  localparam int CONV_SCAN_HI   = 2;
  localparam int CONV_SCAN_LO   = 1;
  localparam int CONV_TEMP_BIT  = 0;
  localparam int SETUP_CK_HI    = 5;
  localparam int SETUP_CK_LO    = 4;
  localparam int SETUP_REF_HI   = 3;
  localparam int SETUP_REF_LO   = 2;
  localparam int SETUP_DIFF_HI  = 1;
  localparam int SETUP_DIFF_LO  = 0;

  // channel and result widths
  localparam int CH_W           = 4;
  localparam int DATA_W         = 12;
  localparam int RESULT_W       = 16;
  localparam logic [3:0] LEAD_PAD = 4'h0;

  typedef enum logic [1:0] {
    CK_INT_PIN     = 2'h0,
    CK_INT_ACQ_PIN = 2'h1,
    CK_INT_FREE    = 2'h2,
    CK_SCLK        = 2'h3
  } clock_mode_t;

  typedef enum logic [1:0] {
    REF_INT_BOTH   = 2'h0,
    REF_EXT_SE     = 2'h1,
    REF_INT_ADC    = 2'h2,
    REF_EXT_DIFF   = 2'h3
  } ref_mode_t;

  typedef enum logic [1:0] {
    SCAN_UP_TO_N   = 2'h0,
    SCAN_N_UP      = 2'h1,
    SCAN_REPEAT    = 2'h2,
    SCAN_SINGLE    = 2'h3
  } scan_mode_t;

  // differential_select targets for the single byte that follows a setup byte
  localparam logic [1:0] DIFF_TO_UNI  = 2'h2;
  localparam logic [1:0] DIFF_TO_BIP  = 2'h3;

  // reset values
  localparam clock_mode_t CLOCK_MODE_RST = CK_INT_FREE;
  localparam ref_mode_t   REF_MODE_RST   = REF_INT_ADC;
  localparam logic [1:0]  DIFF_SEL_RST   = 2'h0;

  // serial framing
  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [1:0] NBYTE_SAT  = 2'h2;
  localparam logic [1:0] NBYTE_WORD = 2'h1;

  // repeat mode: results per repeat_count_select step
  localparam logic [4:0] REPEAT_STEP = 5'h04;

endpackage
`default_nettype wire

/* src/adc_scan_setup_control.sv */
// Overview of operation
// - internal oscillator runs in clock modes 00, 01 and 10.
// - clock mode 11 takes conversion timing from the serial clock.
// - reference_select picks internal, single-ended or differential external references.
// - reference_two_pin is analog input for 00/10, negative reference for 01/11.
// - bit 0 of a conversion byte requests one temperature measurement per scan.
// - temperature is first minus second biased conversion, less Kelvin offset.
// - temperature uses internal reference, two's complement, eighth degree per LSB.
// - temperature converts first, so it is read out before channel results.
// - a newer temperature result overwrites an unread one.
// - byte with bit 7 set is conversion: channel, scan, temperature fields.
// - channel_select is plain binary channel number 0 to 15.
// - scan modes: 0..N, N..top, N repeated, N once.
// - modes 10/11 start on conversion write, 00/01 on convert_start_pin pulse.
// - channels used as convert_start_pin or reference_two_pin are skipped.
// - differential pairs ignore channel bit 0 and convert as one channel.
// - scan modes 00/01 give one result per channel or pair, plus temperature.
// - byte 01xxxxxx is setup: clock mode, reference, differential select.
// - upper clock mode bit is one after power-up.
// - differential_select steers the one byte that follows in the frame to unipolar or bipolar config.
// - clock mode sets clock source, acquisition timing and start source.
// - mode 00 pin start, 01 pin-timed acquisition, 10 pin freed, 11 serial clock.
// - results go out as two bytes, four zeros first; zeros when empty.
// - temperature is twelve bits after four zeros, in first two bytes read.
`timescale 1ns/1ps
`default_nettype none
module adc_scan_setup_control
  import adc_scan_pkg::*;
#(
  parameter int                NUM_CH        = 16,
  parameter int                FIFO_DEPTH    = 16,
  parameter logic [DATA_W-1:0] KELVIN_OFFSET = 12'h888
)(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              din_i,
  input  wire logic              convert_start_pin_n_i,
  input  wire logic              conv_done_i,
  input  wire logic [DATA_W-1:0] conv_data_i,
  input  wire logic [1:0]        repeat_count_select_i,
  output logic                   dout_o,
  output logic                   osc_en_o,
  output logic                   sclk_timing_o,
  output logic                   acq_ext_o,
  output logic                   convert_start_pin_is_input_o,
  output logic                   adc_ref_int_o,
  output logic                   adc_ref_diff_o,
  output logic                   dac_ref_ext_o,
  output logic                   reference_two_pin_is_neg_ref_o,
  output logic                   conv_req_o,
  output logic [CH_W-1:0]        conv_chan_o,
  output logic                   conv_diff_o,
  output logic                   conv_bipolar_o,
  output logic                   conv_temp_o,
  output logic                   conv_bias_hi_o,
  output logic                   conv_int_ref_o,
  output logic                   busy_o,
  output logic                   other_cmd_valid_o,
  output logic [CMD_W-1:0]       other_cmd_byte_o
);

  localparam int NPAIR = NUM_CH / 2;
  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam logic [CH_W:0]   CH_TOP  = (CH_W+1)'(NUM_CH - 1);
  localparam logic [CH_W-1:0] CNV_CH  = CH_W'(NUM_CH - 1);
  localparam logic [CH_W-1:0] REFERENCE_TWO_PIN_CH = CH_W'(NUM_CH - 2);
  localparam logic [PTR_W:0]  FIFO_FULL = (PTR_W+1)'(FIFO_DEPTH);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TEMP_HI,
    ST_TEMP_LO,
    ST_PICK,
    ST_CONV
  } scan_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // link side, serial clock domain

  logic [2:0]          bit_q;
  logic [1:0]          nbyte_q;
  logic [6:0]          sh_in_q;
  logic [CMD_W-1:0]    rx_byte_q;
  logic                rx_first_q;
  logic                rx_tgl_q;
  logic [RESULT_W-1:0] tx_q;
  logic                dout_q;
  logic                pop_tgl_q;
  logic [RESULT_W-1:0] head_word_q;

  // frame position clears whenever chip select is high or reset is low
  always_ff @(posedge sclk_i or posedge cs_n_i or negedge rstn_i)
  begin
    if (cs_n_i || !rstn_i)
    begin
      bit_q   <= 3'h0;
      nbyte_q <= 2'h0;
    end
    else
    begin
      bit_q <= bit_q + 3'h1;
      if (bit_q == BIT_LAST && nbyte_q != NBYTE_SAT)
      begin
        nbyte_q <= nbyte_q + 2'h1;
      end
    end
  end

  // received bytes are held for eight edges, long enough for the toggle crossing
  always_ff @(posedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sh_in_q    <= 7'h00;
      rx_byte_q  <= 8'h00;
      rx_first_q <= 1'b0;
      rx_tgl_q   <= 1'b0;
    end
    else
    begin
      sh_in_q <= {sh_in_q[5:0], din_i};
      if (bit_q == BIT_LAST)
      begin
        rx_byte_q  <= {sh_in_q, din_i};
        rx_first_q <= (nbyte_q == 2'h0);
        rx_tgl_q   <= ~rx_tgl_q;
      end
    end
  end

  // head word is frozen while chip select is low, so it is stable here
  always_ff @(posedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      tx_q      <= 16'h0000;
      dout_q    <= 1'b0;
      pop_tgl_q <= 1'b0;
    end
    else
    begin
      if (bit_q == 3'h0 && nbyte_q == 2'h0)
      begin
        dout_q <= head_word_q[RESULT_W-1];
        tx_q   <= {head_word_q[RESULT_W-2:0], 1'b0};
      end
      else
      begin
        dout_q <= tx_q[RESULT_W-1];
        tx_q   <= {tx_q[RESULT_W-2:0], 1'b0};
      end
      if (bit_q == BIT_LAST && nbyte_q == NBYTE_WORD)
      begin
        pop_tgl_q <= ~pop_tgl_q;
      end
    end
  end

  assign dout_o = dout_q;

  ////////////////////////////////////////////////////////////////////////////
  // crossings into the system clock domain

  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] sync3_q;

  // bit 0 byte toggle, 1 pop toggle, 2 chip select, 3 convert_start_pin
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sync1_q <= 4'hC;
      sync2_q <= 4'hC;
      sync3_q <= 4'hC;
    end
    else
    begin
      sync1_q <= {convert_start_pin_n_i, cs_n_i, pop_tgl_q, rx_tgl_q};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic rx_ev;
  logic pop_ev;
  logic cs_idle;
  logic convert_start_pin_fall;
  logic convert_start_pin_rise;
  assign rx_ev      = sync2_q[0] ^ sync3_q[0];
  assign pop_ev     = sync2_q[1] ^ sync3_q[1];
  assign cs_idle    = sync2_q[2];
  assign convert_start_pin_fall = sync3_q[3] & ~sync2_q[3];
  assign convert_start_pin_rise = ~sync3_q[3] & sync2_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  clock_mode_t       clock_mode_q;
  ref_mode_t         ref_mode_q;
  logic [1:0]        diff_sel_q;
  logic [1:0]        pend_tgt_q;
  logic [NPAIR-1:0]  uni_pairs_q;
  logic [NPAIR-1:0]  bip_pairs_q;
  logic [CH_W-1:0]   chan_sel_q;
  scan_mode_t        scan_mode_q;
  logic              temp_req_q;
  logic              conv_wr_q;
  logic              other_valid_q;
  logic [CMD_W-1:0]  other_byte_q;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      clock_mode_q  <= CLOCK_MODE_RST;
      ref_mode_q    <= REF_MODE_RST;
      diff_sel_q    <= DIFF_SEL_RST;
      pend_tgt_q    <= DIFF_SEL_RST;
      uni_pairs_q   <= '0;
      bip_pairs_q   <= '0;
      chan_sel_q    <= 4'h0;
      scan_mode_q   <= SCAN_UP_TO_N;
      temp_req_q    <= 1'b0;
      conv_wr_q     <= 1'b0;
      other_valid_q <= 1'b0;
      other_byte_q  <= 8'h00;
    end
    else
    begin
      conv_wr_q     <= 1'b0;
      other_valid_q <= 1'b0;
      if (rx_ev && rx_first_q)
      begin
        pend_tgt_q <= DIFF_SEL_RST;
        if (rx_byte_q[CMD_CONV_BIT])
        begin
          chan_sel_q  <= rx_byte_q[CONV_CH_HI:CONV_CH_LO];
          scan_mode_q <= scan_mode_t'(rx_byte_q[CONV_SCAN_HI:CONV_SCAN_LO]);
          temp_req_q  <= rx_byte_q[CONV_TEMP_BIT];
          conv_wr_q   <= 1'b1;
        end
        else if (rx_byte_q[CMD_SETUP_BIT])
        begin
          clock_mode_q <= clock_mode_t'(rx_byte_q[SETUP_CK_HI:SETUP_CK_LO]);
          ref_mode_q   <= ref_mode_t'(rx_byte_q[SETUP_REF_HI:SETUP_REF_LO]);
          diff_sel_q   <= rx_byte_q[SETUP_DIFF_HI:SETUP_DIFF_LO];
          pend_tgt_q   <= rx_byte_q[SETUP_DIFF_HI:SETUP_DIFF_LO];
        end
        else
        begin
          other_valid_q <= 1'b1;
          other_byte_q  <= rx_byte_q;
        end
      end
      else if (rx_ev)
      begin
        // next byte lands in the selected mode register
        if (pend_tgt_q == DIFF_TO_UNI)
        begin
          uni_pairs_q <= rx_byte_q[NPAIR-1:0];
        end
        else if (pend_tgt_q == DIFF_TO_BIP)
        begin
          bip_pairs_q <= rx_byte_q[NPAIR-1:0];
        end
        pend_tgt_q <= DIFF_SEL_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scan sequencer

  scan_state_t       state_q;
  logic [CH_W:0]     cur_q;
  logic [CH_W:0]     first_q;
  logic [CH_W:0]     last_q;
  logic [4:0]        rep_q;
  logic [DATA_W-1:0] t_hi_q;
  logic              req_q;
  logic [CH_W-1:0]   chan_q;
  logic              diff_q;
  logic              bip_q;
  logic              temp_q;
  logic              bias_hi_q;
  logic              busy_q;

  logic              start;
  logic              cnv_reserved;
  logic              ref_reserved;
  logic [CH_W-1:0]   cur_ch;
  logic              cur_diff;
  logic              cur_skip;
  logic              push;
  logic              temp_set;
  logic [DATA_W-1:0] temp_val;

  function automatic logic is_reserved(input logic [CH_W-1:0] ch, input logic cnv, input logic reference_two_pin);
    is_reserved = (cnv && ch == CNV_CH) || (reference_two_pin && ch == REFERENCE_TWO_PIN_CH);
  endfunction

  assign start = (conv_wr_q && (clock_mode_q == CK_INT_FREE || clock_mode_q == CK_SCLK))
              || (convert_start_pin_fall && clock_mode_q == CK_INT_PIN)
              || (convert_start_pin_rise && clock_mode_q == CK_INT_ACQ_PIN);

  // pins given to convert start or reference
  assign cnv_reserved = (clock_mode_q == CK_INT_PIN) || (clock_mode_q == CK_INT_ACQ_PIN);
  assign ref_reserved = (ref_mode_q == REF_EXT_SE) || (ref_mode_q == REF_EXT_DIFF);
  assign cur_diff     = uni_pairs_q[cur_q[CH_W-1:1]] | bip_pairs_q[cur_q[CH_W-1:1]];
  // pair converts at its even member
  assign cur_ch       = cur_diff ? {cur_q[CH_W-1:1], 1'b0} : cur_q[CH_W-1:0];

  always_comb
  begin
    cur_skip = is_reserved(cur_q[CH_W-1:0], cnv_reserved, ref_reserved);
    if (cur_diff)
    begin
      // whole pair dropped if either pin is taken
      cur_skip = is_reserved({cur_q[CH_W-1:1], 1'b0}, cnv_reserved, ref_reserved)
              || is_reserved({cur_q[CH_W-1:1], 1'b1}, cnv_reserved, ref_reserved)
              || (cur_q[0] && cur_q != first_q);
    end
  end

  assign push     = (state_q == ST_CONV) && req_q && conv_done_i;
  assign temp_set = (state_q == ST_TEMP_LO) && req_q && conv_done_i;
  assign temp_val = t_hi_q - conv_data_i - KELVIN_OFFSET;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_q   <= ST_IDLE;
      cur_q     <= 5'h00;
      first_q   <= 5'h00;
      last_q    <= 5'h00;
      rep_q     <= 5'h00;
      t_hi_q    <= 12'h000;
      req_q     <= 1'b0;
      chan_q    <= 4'h0;
      diff_q    <= 1'b0;
      bip_q     <= 1'b0;
      temp_q    <= 1'b0;
      bias_hi_q <= 1'b0;
      busy_q    <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            // binary channel number; range by scan mode
            unique case (scan_mode_q)
              SCAN_UP_TO_N:
              begin
                first_q <= 5'h00;
                cur_q   <= 5'h00;
                last_q  <= {1'b0, chan_sel_q};
              end
              SCAN_N_UP:
              begin
                first_q <= {1'b0, chan_sel_q};
                cur_q   <= {1'b0, chan_sel_q};
                last_q  <= CH_TOP;
              end
              SCAN_REPEAT, SCAN_SINGLE:
              begin
                first_q <= {1'b0, chan_sel_q};
                cur_q   <= {1'b0, chan_sel_q};
                last_q  <= {1'b0, chan_sel_q};
              end
            endcase
            rep_q <= ({3'h0, repeat_count_select_i} + 5'h01) * REPEAT_STEP;
            state_q <= temp_req_q ? ST_TEMP_HI : ST_PICK;
            busy_q  <= 1'b1;
          end
        end
        ST_TEMP_HI:
        begin
          if (!req_q)
          begin
            req_q     <= 1'b1;
            temp_q    <= 1'b1;
            bias_hi_q <= 1'b1;
          end
          else if (conv_done_i)
          begin
            req_q   <= 1'b0;
            t_hi_q  <= conv_data_i;
            state_q <= ST_TEMP_LO;
          end
        end
        ST_TEMP_LO:
        begin
          if (!req_q)
          begin
            req_q     <= 1'b1;
            bias_hi_q <= 1'b0;
          end
          else if (conv_done_i)
          begin
            req_q   <= 1'b0;
            temp_q  <= 1'b0;
            state_q <= ST_PICK;
          end
        end
        ST_PICK:
        begin
          if (cur_q > last_q)
          begin
            state_q <= ST_IDLE;
            busy_q  <= 1'b0;
          end
          else if (cur_skip)
          begin
            cur_q <= cur_q + 5'h01;
          end
          else
          begin
            req_q   <= 1'b1;
            chan_q  <= cur_ch;
            diff_q  <= cur_diff;
            bip_q   <= bip_pairs_q[cur_q[CH_W-1:1]];
            state_q <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (conv_done_i)
          begin
            req_q   <= 1'b0;
            state_q <= ST_PICK;
            // repeat mode reconverts N until the count runs out
            if (scan_mode_q == SCAN_REPEAT && rep_q > 5'h01)
            begin
              rep_q <= rep_q - 5'h01;
            end
            else
            begin
              cur_q <= cur_q + 5'h01;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result store

  logic [DATA_W-1:0] mem_q [FIFO_DEPTH];
  logic [PTR_W-1:0]  wr_q;
  logic [PTR_W-1:0]  rd_q;
  logic [PTR_W:0]    cnt_q;
  logic [DATA_W-1:0] temp_res_q;
  logic              temp_valid_q;
  logic              head_is_temp_q;
  logic              head_is_fifo_q;
  logic              pop_fifo;

  assign pop_fifo = pop_ev && head_is_fifo_q && cnt_q != '0;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_q] <= conv_data_i;
    end
  end

  // full store drops its oldest entry to make room
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + PTR_W'(1);
      end
      if (pop_fifo || (push && cnt_q == FIFO_FULL))
      begin
        rd_q <= rd_q + PTR_W'(1);
      end
      if (push && !pop_fifo && cnt_q != FIFO_FULL)
      begin
        cnt_q <= cnt_q + (PTR_W+1)'(1);
      end
      else if (pop_fifo && !push)
      begin
        cnt_q <= cnt_q - (PTR_W+1)'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      temp_res_q   <= 12'h000;
      temp_valid_q <= 1'b0;
    end
    else if (temp_set)
    begin
      // newest temperature wins, also over a same-cycle read
      temp_res_q   <= temp_val;
      temp_valid_q <= 1'b1;
    end
    else if (pop_ev && head_is_temp_q)
    begin
      temp_valid_q <= 1'b0;
    end
  end

  // refreshed only while chip select idles, giving the link a stable word
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      head_word_q    <= 16'h0000;
      head_is_temp_q <= 1'b0;
      head_is_fifo_q <= 1'b0;
    end
    else if (cs_idle)
    begin
      head_is_temp_q <= temp_valid_q;
      head_is_fifo_q <= !temp_valid_q && cnt_q != '0;
      // temperature ahead of any channel result
      if (temp_valid_q)
      begin
        head_word_q <= {LEAD_PAD, temp_res_q};
      end
      // four zeros, then twelve data bits; zero when empty
      else if (cnt_q != '0)
      begin
        head_word_q <= {LEAD_PAD, mem_q[rd_q]};
      end
      else
      begin
        head_word_q <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered configuration outputs

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      osc_en_o          <= 1'b1;
      sclk_timing_o     <= 1'b0;
      acq_ext_o         <= 1'b0;
      convert_start_pin_is_input_o  <= 1'b1;
      adc_ref_int_o     <= 1'b1;
      adc_ref_diff_o    <= 1'b0;
      dac_ref_ext_o     <= 1'b1;
      reference_two_pin_is_neg_ref_o <= 1'b0;
    end
    else
    begin
      // clock source, acquisition and pin role
      osc_en_o         <= clock_mode_q != CK_SCLK;
      sclk_timing_o    <= clock_mode_q == CK_SCLK;
      acq_ext_o        <= clock_mode_q == CK_INT_ACQ_PIN;
      convert_start_pin_is_input_o <= clock_mode_q == CK_INT_FREE || clock_mode_q == CK_SCLK;
      adc_ref_int_o    <= ref_mode_q == REF_INT_BOTH || ref_mode_q == REF_INT_ADC;
      adc_ref_diff_o   <= ref_mode_q == REF_EXT_DIFF;
      dac_ref_ext_o    <= ref_mode_q != REF_INT_BOTH;
      reference_two_pin_is_neg_ref_o <= ref_reserved;
    end
  end

  assign conv_req_o        = req_q;
  assign conv_chan_o       = chan_q;
  assign conv_diff_o       = diff_q;
  assign conv_bipolar_o    = bip_q;
  assign conv_temp_o       = temp_q;
  assign conv_bias_hi_o    = bias_hi_q;
  assign conv_int_ref_o    = temp_q;
  assign busy_o            = busy_q;
  assign other_cmd_valid_o = other_valid_q;
  assign other_cmd_byte_o  = other_byte_q;

endmodule
`default_nettype wire

/* test/adc_scan_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_scan_monitor
  import adc_scan_pkg::*;
#(
  parameter int NUM_CH = 16
)(
  input wire logic            clk_i,
  input wire logic            rstn_i,
  input wire logic            conv_done_i,
  input wire logic            osc_en_o,
  input wire logic            sclk_timing_o,
  input wire logic            acq_ext_o,
  input wire logic            convert_start_pin_is_input_o,
  input wire logic            adc_ref_int_o,
  input wire logic            adc_ref_diff_o,
  input wire logic            dac_ref_ext_o,
  input wire logic            reference_two_pin_is_neg_ref_o,
  input wire logic            conv_req_o,
  input wire logic [CH_W-1:0] conv_chan_o,
  input wire logic            conv_temp_o,
  input wire logic            conv_int_ref_o,
  input wire logic            busy_o,
  input wire logic            other_cmd_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  a_osc_mode: assert property (osc_en_o != sclk_timing_o)
    else $error("oscillator and serial timing both on or off");
  a_ref_neg: assert property (adc_ref_int_o != reference_two_pin_is_neg_ref_o)
    else $error("shared pin role disagrees with reference");
  a_ref_diff: assert property (adc_ref_diff_o |-> reference_two_pin_is_neg_ref_o && dac_ref_ext_o)
    else $error("differential reference routing wrong");
  a_acq_pin: assert property (acq_ext_o |-> osc_en_o && !convert_start_pin_is_input_o)
    else $error("pin timed acquisition in wrong mode");
  a_temp_ref: assert property (conv_req_o && conv_temp_o |-> conv_int_ref_o)
    else $error("temperature without internal reference");
  a_req_busy: assert property (conv_req_o |-> busy_o)
    else $error("conversion outside a scan");
  a_req_gap: assert property (conv_req_o && conv_done_i |=> !conv_req_o && busy_o)
    else $error("request not dropped after done");
  a_skip_reserved: assert property (conv_req_o && !conv_temp_o |->
    !(reference_two_pin_is_neg_ref_o && conv_chan_o == CH_W'(NUM_CH-2)) && !(!convert_start_pin_is_input_o && conv_chan_o == CH_W'(NUM_CH-1)))
    else $error("reserved channel converted");
  a_other_pulse: assert property (other_cmd_valid_o |=> !other_cmd_valid_o)
    else $error("other command strobe longer than one cycle");
endmodule
bind adc_scan_setup_control adc_scan_monitor #(.NUM_CH(NUM_CH)) u_mon (.*);
`default_nettype wire

/* test/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    cs_n_o = 1'b0;
    #80;
    for (int i = 0; i < n; i++)
    begin
      din_o = tx[15-i];
      #62.5 sclk_o = 1'b1;
      #62.5 sclk_o = 1'b0;
      rx = {rx[14:0], dout_i};
    end
    #62.5 cs_n_o = 1'b1;
    // released line must not hold last bit
    din_o = ~din_o;
    #100;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adc_scan_pkg::*;
  logic clk_i, rstn_i, sclk_i, cs_n_i, din_i, convert_start_pin_n_i, conv_done_i, dout_o, osc_en_o, sclk_timing_o;
  logic acq_ext_o, convert_start_pin_is_input_o, adc_ref_int_o, adc_ref_diff_o, dac_ref_ext_o, reference_two_pin_is_neg_ref_o;
  logic conv_req_o, conv_diff_o, conv_bipolar_o, conv_temp_o, conv_bias_hi_o, conv_int_ref_o;
  logic busy_o, other_cmd_valid_o;
  logic [1:0]        repeat_count_select_i;
  logic [DATA_W-1:0] conv_data_i;
  logic [CH_W-1:0]   conv_chan_o;
  logic [CMD_W-1:0]  other_cmd_byte_o;
  logic [15:0]       rx;
  int                err_total, checks, cyc;
  adc_scan_setup_control dut (.*);
  spi_host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o));
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // converter answers one cycle after each request
  always @(posedge clk_i)
  begin
    conv_done_i <= #1 conv_req_o & ~conv_done_i;
    conv_data_i <= #1 conv_temp_o ? (conv_bias_hi_o ? 12'hC00 : 12'h100)
                                  : {4'h0, conv_bipolar_o, conv_diff_o, conv_chan_o, 2'h1};
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    host.xfer({b, 8'h00}, 8, rx);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic rd(input logic [15:0] exp);
    host.xfer(16'h0000, 16, rx);
    check(rx, exp);
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 3000 && busy_o !== 1'b0; n++)
      @(posedge clk_i);
    check({15'h0000, busy_o}, 16'h0000);
  endtask
  task automatic pulse_convert_start_pin;
    @(posedge clk_i);
    #1 convert_start_pin_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 convert_start_pin_n_i = 1'b1;
    repeat (8) @(posedge clk_i);
    wait_idle();
  endtask
  function automatic logic [15:0] cfg_exp(input logic [1:0] ck, input logic [1:0] rf);
    return {8'h00, ck != 2'h3, ck == 2'h3, ck == 2'h1, ck[1], !rf[0], rf == 2'h3, rf != 2'h0, rf[0]};
  endfunction
  function automatic logic [15:0] cfg;
    return {8'h00, osc_en_o, sclk_timing_o, acq_ext_o, convert_start_pin_is_input_o, adc_ref_int_o, adc_ref_diff_o,
      dac_ref_ext_o, reference_two_pin_is_neg_ref_o};
  endfunction
  task automatic give_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    err_total = 0;
    checks = 0;
    cyc = 0;
    rstn_i = 1'b1;
    convert_start_pin_n_i = 1'b1;
    repeat_count_select_i = 2'h0;
    // a real falling edge, so the serial side resets as well
    #1 rstn_i = 1'b0;
    repeat (20) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    repeat (4) @(posedge clk_i);
    check(cfg(), cfg_exp(2'h2, 2'h2));
    for (int i = 0; i < 4; i++)
    begin
      cmd({2'b01, 2'(i), 2'(3 - i), 2'b00});
      check(cfg(), cfg_exp(2'(i), 2'(3 - i)));
    end
    cmd(8'h60);
    cmd(8'h89);
    wait_idle();
    rd(16'h0278);
    rd(16'h0001);
    rd(16'h0005);
    rd(16'h0000);
    cmd(8'h64);
    cmd(8'hF2);
    wait_idle();
    rd(16'h003D);
    rd(16'h0000);
    cmd(8'h94);
    wait_idle();
    for (int i = 0; i < 4; i++)
      rd(16'h0009);
    rd(16'h0000);
    cmd(8'h9F);
    wait_idle();
    cmd(8'h9F);
    wait_idle();
    rd(16'h0278);
    rd(16'h000D);
    rd(16'h000D);
    rd(16'h0000);
    cmd(8'h40);
    cmd(8'h9E);
    repeat (60) @(posedge clk_i);
    rd(16'h0000);
    pulse_convert_start_pin();
    rd(16'h000D);
    cmd(8'h2A);
    check({8'h00, other_cmd_byte_o}, 16'h002A);
    check(cfg(), cfg_exp(2'h0, 2'h0));
    host.xfer({8'h62, 8'h01}, 16, rx);
    host.xfer({8'h63, 8'h02}, 16, rx);
    cmd(8'h98);
    wait_idle();
    rd(16'h0041);
    rd(16'h00C9);
    rd(16'h0000);
    cmd(8'h50);
    cmd(8'h9E);
    pulse_convert_start_pin();
    rd(16'h00C9);
    give_verdict();
  end
endmodule
`default_nettype wire
